// ===== rtl/xcfg_pkg.sv
/*
  constants of the crosspoint serial configuration logic.
  assumes nothing of its surroundings.
*/
package xcfg_pkg;
  localparam int NUM_OUT    = 16;
  localparam int SEL_W      = 5;
  localparam int FIELD_W    = 6;
  localparam int FRAME_BITS = NUM_OUT * FIELD_W;
  localparam int ADDR_W     = 4;
  localparam int WORD_BITS  = 10;
  localparam int WORD_OUT_LSB = 0;
  localparam int WORD_SEL_LSB = 4;
  localparam int WORD_OFF_BIT = 9;
  localparam int FIELD_OFF_BIT = 5;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
  localparam logic             OFF_RESET = 1'h1;
  localparam logic             OFF_ON    = 1'h0;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [0:0] {
    XCFG_IDLE  = 1'b0,
    XCFG_ARMED = 1'b1
  } xcfg_link_t;
endpackage

// ===== rtl/xcfg_crosspoint_serial_config.sv
/*
  serial configuration logic of a 32 input, 16 output crosspoint:
  four wire serial port, staging bank, active bank, clear and
  connect-all overrides.
  assumes all pins come from outside the clock domain; the serial
  clock is far slower than clock and is sampled, not used as a clock.
*/
`timescale 1ns/100ps
module xcfg_crosspoint_serial_config #(
  parameter int NUM_OUT    = xcfg_pkg::NUM_OUT,
  parameter int SEL_W      = xcfg_pkg::SEL_W
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // serial port pins
  input  wire logic                     ser_clk,
  input  wire logic                     ser_din,
  input  wire logic                     cs_b,
  input  wire logic                     cfg,
  input  wire logic                     mode,
  output logic                          ser_dout,
  // override pins
  input  wire logic                     clear,
  input  wire logic                     connect_all_to_first_input,
  // switch matrix settings
  output logic [NUM_OUT*SEL_W-1:0]      out_sel,
  output logic [NUM_OUT-1:0]            out_off
);

  localparam int FW = xcfg_pkg::FIELD_W;
  localparam int FB = NUM_OUT * FW;
  localparam int WB = xcfg_pkg::WORD_BITS;
  localparam int NS = xcfg_pkg::SYNC_STAGES;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, plus one extra stage for edge finding
  logic [NS-1:0] clk_s_q;
  logic [NS-1:0] din_s_q;
  logic [NS-1:0] cs_s_q;
  logic [NS-1:0] cfg_s_q;
  logic [NS-1:0] mode_s_q;
  logic [NS-1:0] clr_s_q;
  logic [NS-1:0] all_s_q;
  logic          clk_d1_q;
  logic          cs_d1_q;
  logic          cfg_d1_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_s_q  <= '0;
      din_s_q  <= '0;
      cs_s_q   <= '1;
      cfg_s_q  <= '0;
      mode_s_q <= '0;
      clr_s_q  <= '0;
      all_s_q  <= '0;
      clk_d1_q <= 1'b0;
      cs_d1_q  <= 1'b1;
      cfg_d1_q <= 1'b0;
    end
    else
    begin
      clk_s_q  <= {clk_s_q[NS-2:0], ser_clk};
      din_s_q  <= {din_s_q[NS-2:0], ser_din};
      cs_s_q   <= {cs_s_q[NS-2:0], cs_b};
      cfg_s_q  <= {cfg_s_q[NS-2:0], cfg};
      mode_s_q <= {mode_s_q[NS-2:0], mode};
      clr_s_q  <= {clr_s_q[NS-2:0], clear};
      all_s_q  <= {all_s_q[NS-2:0], connect_all_to_first_input};
      clk_d1_q <= clk_s_q[NS-1];
      cs_d1_q  <= cs_s_q[NS-1];
      cfg_d1_q <= cfg_s_q[NS-1];
    end
  end

  logic sclk;
  logic sdin;
  logic scs_b;
  logic smode;
  logic sclr;
  logic sall;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cfg_rise;

  assign sclk      = clk_s_q[NS-1];
  assign sdin      = din_s_q[NS-1];
  assign scs_b     = cs_s_q[NS-1];
  assign smode     = mode_s_q[NS-1];
  assign sclr      = clr_s_q[NS-1];
  assign sall      = all_s_q[NS-1];
  assign sclk_rise = sclk & ~clk_d1_q;
  assign sclk_fall = ~sclk & clk_d1_q;
  assign cs_rise   = scs_b & ~cs_d1_q;
  assign cfg_rise  = cfg_s_q[NS-1] & ~cfg_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // link state: armed by the first rising serial clock with chip select low
  xcfg_pkg::xcfg_link_t link_q;
  logic                 shift_en;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      link_q <= xcfg_pkg::XCFG_IDLE;
    else
    begin
      case (link_q)
        xcfg_pkg::XCFG_IDLE:
          if (!scs_b && sclk_rise)
            link_q <= xcfg_pkg::XCFG_ARMED;
        xcfg_pkg::XCFG_ARMED:
          if (scs_b)
            link_q <= xcfg_pkg::XCFG_IDLE;
        default:
          link_q <= xcfg_pkg::XCFG_IDLE;
      endcase
    end
  end

  assign shift_en = (link_q == xcfg_pkg::XCFG_ARMED) && !scs_b
                    && sclk_fall;

  ////////////////////////////////////////////////////////////////////////
  // staging bank: frame shift register and addressed word register
  logic [FB-1:0] frame_q;
  logic [WB-1:0] word_q;
  logic [xcfg_pkg::ADDR_W-1:0] word_out;

  assign word_out = word_q[xcfg_pkg::WORD_OUT_LSB +: xcfg_pkg::ADDR_W];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      word_q <= '0;
    else if (shift_en && smode)
      word_q <= {sdin, word_q[WB-1:1]};
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      frame_q <= '0;
    else if (shift_en && !smode)
      frame_q <= {sdin, frame_q[FB-1:1]};
    else if (cs_rise && smode && link_q == xcfg_pkg::XCFG_ARMED)
    begin
      frame_q[int'(word_out)*FW +: FW] <=
        {word_q[xcfg_pkg::WORD_OFF_BIT],
         word_q[xcfg_pkg::WORD_SEL_LSB +: SEL_W]};
    end
  end

  // data out: old contents leave first, only in full-frame format
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ser_dout <= 1'b0;
    else if (smode)
      ser_dout <= 1'b0;
    else
      ser_dout <= frame_q[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // new data flag: any accepted bit sets it, a taken configure clears it
  logic new_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      new_q <= 1'b0;
    else if (shift_en)
      new_q <= 1'b1;
    else if (cfg_rise)
      new_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // active bank driving the matrix
  logic [SEL_W-1:0] sel_q [NUM_OUT];
  logic             off_q [NUM_OUT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          sel_q[gi] <= xcfg_pkg::SEL_RESET;
          off_q[gi] <= xcfg_pkg::OFF_RESET;
        end
        else if (sclr)
        begin
          sel_q[gi] <= xcfg_pkg::SEL_RESET;
          off_q[gi] <= xcfg_pkg::OFF_RESET;
        end
        else if (sall)
        begin
          sel_q[gi] <= xcfg_pkg::SEL_RESET;
          off_q[gi] <= xcfg_pkg::OFF_ON;
        end
        else if (cfg_rise && new_q)
        begin
          sel_q[gi] <= frame_q[gi*FW +: SEL_W];
          off_q[gi] <= frame_q[gi*FW + xcfg_pkg::FIELD_OFF_BIT];
        end
      end
      assign out_sel[gi*SEL_W +: SEL_W] = sel_q[gi];
      assign out_off[gi]                = off_q[gi];
    end
  endgenerate

endmodule // xcfg_crosspoint_serial_config

// ===== tb/xcfg_host.sv
/* controller model on the serial pins; assumes a 50 MHz clock. */
`timescale 1ns/100ps
module xcfg_host (
  // clock
  input  wire logic clock,
  // serial pins
  output logic      ser_clk,
  output logic      ser_din,
  output logic      cs_b,
  input  wire logic ser_dout
);
  logic [95:0] cap;
  initial
  begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    cs_b = 1'b1;
  end
  // half of a 160 ns serial period
  task automatic half();
    repeat (4) @(posedge clock);
  endtask
  // frame or word, bit 0 first; captures data out
  task automatic send(input logic [95:0] v, input int n);
    cs_b <= 1'b0;
    half();
    for (int i = 0; i < n; i++)
    begin
      ser_clk <= 1'b1;
      ser_din <= v[i];
      half();
      cap[i] = ser_dout;
      ser_clk <= 1'b0;
      half();
    end
    cs_b <= 1'b1;
    ser_din <= ~ser_din;
    half();
    ser_clk <= 1'b1;
    half();
    ser_clk <= 1'b0;
    half();
  endtask
  // clock and data toggling while deselected
  task automatic noise();
    repeat (3)
    begin
      ser_clk <= 1'b1;
      ser_din <= ~ser_din;
      half();
      ser_clk <= 1'b0;
      half();
    end
  endtask
endmodule // xcfg_host

// ===== tb/xcfg_crosspoint_serial_config_chk.sv
/* checker on the top ports; bound below, one clock domain. */
`timescale 1ns/100ps
module xcfg_chk #(parameter int NUM_OUT = 16, parameter int SEL_W = 5) (
  // clock, reset
  input wire logic                     clock,
  input wire logic                     rst_b,
  // pins
  input wire logic                     cs_b,
  input wire logic                     cfg,
  input wire logic                     mode,
  input wire logic                     ser_dout,
  input wire logic                     clear,
  input wire logic                     connect_all_to_first_input,
  // matrix
  input wire logic [NUM_OUT*SEL_W-1:0] out_sel,
  input wire logic [NUM_OUT-1:0]       out_off
);
  wire ca = connect_all_to_first_input;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  clear_off_a: assert property (clear [*5] |-> &out_off)
    else $error("clear off");
  clear_sel_a: assert property (clear [*5] |-> out_sel == '0)
    else $error("clear sel");
  bcast_on_a: assert property ((ca && !clear) [*5]
    |-> out_off == '0) else $error("bcast off");
  bcast_sel_a: assert property (ca [*5] |-> out_sel == '0)
    else $error("bcast sel");
  clear_wins_a: assert property ((clear && ca) [*5] |-> &out_off)
    else $error("clear priority");
  word_dout_a: assert property (mode [*8] |-> !ser_dout)
    else $error("dout in word mode");
  idle_dout_a: assert property ((cs_b && !mode) [*8]
    |=> $stable(ser_dout)) else $error("dout while idle");
  hold_out_a: assert property ((!cfg && !clear && !ca) [*6]
    |=> $stable(out_sel) && $stable(out_off)) else $error("outputs moved");
endmodule // xcfg_chk
bind xcfg_crosspoint_serial_config xcfg_chk #(
  .NUM_OUT(NUM_OUT),
  .SEL_W(SEL_W)
) chk (.clock(clock), .rst_b(rst_b), .cs_b(cs_b), .cfg(cfg), .mode(mode),
  .ser_dout(ser_dout), .clear(clear),
  .connect_all_to_first_input(connect_all_to_first_input),
  .out_sel(out_sel), .out_off(out_off));

// ===== tb/test_crosspoint_serial_config.sv
/* bench of the serial config block; uses xcfg_host as controller. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %0h got %0h", n, e, g); \
  end end
module test_crosspoint_serial_config;
  logic        clock, rst_b, cfg, mode, clear, conn, sclk, sdin, cs_b, sdout;
  logic [79:0] out_sel, es;
  logic [15:0] out_off, eo;
  logic [95:0] fa, fb;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  xcfg_host host (.clock(clock), .ser_clk(sclk), .ser_din(sdin),
    .cs_b(cs_b), .ser_dout(sdout));
  xcfg_crosspoint_serial_config uut (.clock(clock), .rst_b(rst_b),
    .ser_clk(sclk), .ser_din(sdin), .cs_b(cs_b), .cfg(cfg), .mode(mode),
    .ser_dout(sdout), .clear(clear), .connect_all_to_first_input(conn),
    .out_sel(out_sel), .out_off(out_off));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  // strobe only after the transfer is complete
  task automatic pulse();
    cfg <= 1'b1;
    wait_n(6);
    cfg <= 1'b0;
    wait_n(8);
  endtask
  task automatic expect_frame(input logic [95:0] f);
    for (int k = 0; k < 16; k++)
    begin
      es[5*k +: 5] = f[6*k +: 5];
      eo[k] = f[6*k+5];
    end
    `CHK("sel", es, out_sel)
    `CHK("off", eo, out_off)
  endtask
  task automatic t_frame();
    host.send(fa, 96);
    `CHK("staged", 16'hffff, out_off)
    pulse();
    expect_frame(fa);
    $display("test frame done");
  endtask
  task automatic t_over();
    clear <= 1'b1;
    wait_n(6);
    `CHK("clr sel", 80'h0, out_sel)
    `CHK("clr off", 16'hffff, out_off)
    conn <= 1'b1;
    wait_n(6);
    `CHK("both", 16'hffff, out_off)
    clear <= 1'b0;
    wait_n(6);
    `CHK("bc off", 16'h0, out_off)
    `CHK("bc sel", 80'h0, out_sel)
    conn <= 1'b0;
    host.noise();
    pulse();
    `CHK("empty cfg", 16'h0, out_off)
    $display("test override done");
  endtask
  task automatic t_addr();
    mode <= 1'b1;
    wait_n(4);
    host.send({86'h0, 1'b0, 5'h11, 4'h5}, 10);
    pulse();
    fa[35:30] = {1'b0, 5'h11};
    expect_frame(fa);
    $display("test word done");
  endtask
  task automatic t_chain();
    mode <= 1'b0;
    wait_n(4);
    host.send(fb, 96);
    `CHK("dout", fa, host.cap)
    pulse();
    expect_frame(fb);
    // connect-all over a loaded frame whose selects are not zero
    conn <= 1'b1;
    wait_n(6);
    `CHK("bc sel2", 80'h0, out_sel)
    `CHK("bc off2", 16'h0, out_off)
    conn <= 1'b0;
    $display("test chain done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    {rst_b, cfg, mode, clear, conn} = 5'h00;
    for (int k = 0; k < 16; k++)
      {fa[6*k +: 6], fb[6*k +: 6]} = {k[0], 5'(k + 3), ~k[0], 5'(31 - k)};
    wait_n(6);
    rst_b <= 1'b1;
    wait_n(4);
    t_frame();
    t_over();
    t_addr();
    t_chain();
    summarize();
  end
endmodule // test_crosspoint_serial_config
